// *** rtl/tblwr_exec.sv ***
// execution block for table writes and the subtract pair
// assumes the core issues one command while busy is low, and that the
// program memory accepts a word on pm_wr_stb and, if internal, answers
// with pm_done when its programming pulse ends
// Contract
// - table write first copies the file value into one latch half
// - half select 0 loads low latch byte, 1 loads high byte
// - then the whole 16-bit latch is written at the pointer
// - external target: store takes exactly two instruction cycles
// - internal target: write lasts until done, or ends on interrupt
// - increment bit 1 advances pointer after write, 0 leaves it
// - normal supply on program pin: sequence runs, word not programmed
`timescale 1ns/1ps
module tblwr_exec #(
  parameter bit SMALL_VARIANT = 1'b0  // keep only four bank bits
) (
  input  wire logic              ref_clk,     // core clock
  input  wire logic              rst_n,       // sync reset, active low
  input  wire logic              cmd_valid,   // command strobe
  input  tblwr_pkg::cmd_t        cmd,         // decoded command
  input  wire logic              ptr_load,    // software pointer load
  input  wire logic [15:0]       ptr_val,     // pointer load value
  input  wire logic              bank_wr,     // bank select write
  input  wire logic [7:0]        bank_val,    // bank select value
  input  wire logic              work_wr,     // working register write
  input  wire logic [7:0]        work_val,    // working register value
  input  wire logic              ptr_is_int,  // pointer hits internal
  input  wire logic              vpp_high,    // program pin at prog level
  input  wire logic              irq,         // interrupt received
  input  wire logic              pm_done,     // internal program done
  output logic                   busy,        // command in progress
  output logic                   pm_wr_stb,   // word write strobe
  output logic                   pm_prog_en,  // programming enabled
  output logic [15:0]            pm_addr,     // program word address
  output logic [15:0]            pm_data,     // program word data
  output logic [15:0]            program_word_pointer, // pointer
  output logic [15:0]            program_word_latch,   // table latch
  output logic [7:0]             bank_select_reg,      // bank readback
  output logic [7:0]             working_reg,          // working reg
  output tblwr_pkg::flags_t      alu_flags,   // status flags
  output logic                   file_wr,     // file write pulse
  output logic [7:0]             file_wr_val  // file write data
);
  import tblwr_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXT  = 2'b01,
    ST_INT  = 2'b10
  } state_t;

  state_t      state_q;
  logic [1:0]  phase_q;
  logic [2:0]  cyc_q;
  logic        inc_q;
  logic        prog_q;
  logic        stb_q;
  logic [15:0] ptr_q;
  logic [15:0] latch_q;
  logic [7:0]  bank_q;
  logic [7:0]  work_q;
  flags_t      flags_q;
  logic        fwr_q;
  logic [7:0]  fval_q;
  logic        start_st;
  logic        start_sub;
  logic        cyc_end;
  logic        st_end;
  flags_t      sub_flags;
  logic [7:0]  sub_res;

  assign busy      = (state_q != ST_IDLE);
  assign start_st  = cmd_valid & ~busy & (cmd.op == OP_STORE);
  assign start_sub = cmd_valid & ~busy &
                     ((cmd.op == OP_SUB) | (cmd.op == OP_SUBB));
  assign cyc_end   = (phase_q == PH_LAST);
  // internal writes stop on completion or on the first interrupt
  assign st_end    = ((state_q == ST_EXT) & cyc_end & (cyc_q == EXT_LAST)) |
                     ((state_q == ST_INT) & (pm_done | irq));

  // four-phase instruction timing, restarts with each store
  always_ff @(posedge ref_clk) begin
    if (!rst_n | start_st) begin
      phase_q <= PH_FIRST;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n | start_st) begin
      cyc_q <= 3'h0;
    end else if (cyc_end) begin
      cyc_q <= cyc_q + 3'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else if (start_st) begin
      state_q <= ptr_is_int ? ST_INT : ST_EXT;
    end else if (st_end) begin
      state_q <= ST_IDLE;
    end
  end

  // latch half is loaded in the issue cycle, before the word goes out
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      latch_q <= LATCH_RST;
    end else if (start_st) begin
      if (cmd.half_sel) begin
        latch_q[15:8] <= cmd.file_val;
      end else begin
        latch_q[7:0] <= cmd.file_val;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      inc_q  <= 1'b0;
      prog_q <= 1'b0;
    end else if (start_st) begin
      inc_q  <= cmd.ptr_inc;
      prog_q <= vpp_high;
    end
  end

  // one write strobe, the cycle after the latch half is loaded
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stb_q <= 1'b0;
    end else begin
      stb_q <= start_st;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ptr_q <= PTR_RST;
    end else if (st_end & inc_q) begin
      ptr_q <= ptr_q + 16'h0001;
    end else if (ptr_load & ~busy) begin
      ptr_q <= ptr_val;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bank_q <= BANK_RST;
    end else if (bank_wr) begin
      bank_q <= SMALL_VARIANT ? (bank_val & BANK_LO_MASK) : bank_val;
    end
  end

  sub_alu u_sub (
    .file_val   (cmd.file_val),
    .work_val   (work_q),
    .use_borrow (cmd.op == OP_SUBB),
    .carry_in   (flags_q.c),
    .flags      (sub_flags),
    .result     (sub_res)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else if (start_sub) begin
      flags_q <= sub_flags;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      work_q <= WORKING_REG_RST;
    end else if (start_sub & ~cmd.dest_file) begin
      work_q <= sub_res;
    end else if (work_wr) begin
      work_q <= work_val;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fwr_q  <= 1'b0;
      fval_q <= 8'h00;
    end else begin
      fwr_q <= start_sub & cmd.dest_file;
      if (start_sub & cmd.dest_file) begin
        fval_q <= sub_res;
      end
    end
  end

  assign pm_wr_stb            = stb_q;
  assign pm_prog_en           = busy & prog_q & (state_q == ST_INT);
  assign pm_addr              = ptr_q;
  assign pm_data              = latch_q;
  assign program_word_pointer = ptr_q;
  assign program_word_latch   = latch_q;
  assign bank_select_reg      = bank_q;
  assign working_reg          = work_q;
  assign alu_flags            = flags_q;
  assign file_wr              = fwr_q;
  assign file_wr_val          = fval_q;

  sequence s_ext_start;
    start_st & ~ptr_is_int;
  endsequence

  AST_EXT_TWO_CYCLES: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_ext_start |=> busy [*8] ##1 !busy)
    else $error("external store not two instruction cycles");

  AST_INT_IRQ_END: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == ST_INT) & irq |=> !busy)
    else $error("internal store not ended by interrupt");

  AST_STROBE_AFTER_LOAD: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    start_st |=> pm_wr_stb & (pm_addr == $past(ptr_q)))
    else $error("write strobe not one cycle after latch load");

  AST_LOW_HALF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    start_st & !cmd.half_sel |=>
      latch_q[7:0] == $past(cmd.file_val) &&
      latch_q[15:8] == $past(latch_q[15:8]))
    else $error("low latch half load wrong");

  AST_HIGH_HALF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    start_st & cmd.half_sel |=> latch_q[15:8] == $past(cmd.file_val))
    else $error("high latch half load wrong");

  AST_PTR_INC: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_end & inc_q |=> ptr_q == $past(ptr_q) + 16'h0001)
    else $error("pointer not advanced");

  AST_PTR_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    busy & !inc_q |=> $stable(ptr_q))
    else $error("pointer moved without increment");

  AST_NO_PROG_LOW_VPP: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    start_st & ptr_is_int & !vpp_high |=> busy & !pm_prog_en)
    else $error("programming enabled at normal supply");

  AST_BANK_UPPER_ZERO: assert property (@(posedge ref_clk)
    disable iff (!rst_n)
    SMALL_VARIANT |-> bank_select_reg[7:4] == 4'h0)
    else $error("upper bank bits not zero");

  AST_SUB_DEST: assert property (@(posedge ref_clk) disable iff (!rst_n)
    start_sub & cmd.dest_file |=> file_wr && $stable(working_reg))
    else $error("subtract destination wrong");
endmodule

// *** rtl/tblwr_pkg.sv ***
// shared types and constants for the table-write execution block
// assumes a four-phase instruction cycle made from the core clock
package tblwr_pkg;
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PHASES        = 4;
  localparam logic [1:0]  PH_LAST       = 2'h3;
  localparam logic [1:0]  PH_FIRST      = 2'h0;
  localparam int unsigned EXT_CYCLES    = 2;
  localparam logic [2:0]  EXT_LAST      = 3'h1;
  localparam logic [7:0]  BANK_LO_MASK  = 8'h0f;
  localparam logic [15:0] PTR_RST       = 16'h0000;
  localparam logic [15:0] LATCH_RST     = 16'h0000;
  localparam logic [7:0]  WORKING_REG_RST      = 8'h00;
  localparam logic [7:0]  BANK_RST      = 8'h00;

  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_STORE = 2'b01,
    OP_SUB   = 2'b10,
    OP_SUBB  = 2'b11
  } op_t;

  typedef struct packed {
    op_t        op;
    logic       half_sel;   // store: 0 low byte, 1 high byte
    logic       ptr_inc;    // store: advance pointer
    logic       dest_file;  // subtract: 1 result to file register
    logic [7:0] file_val;   // value read from the file register
  } cmd_t;

  typedef struct packed {
    logic ov;
    logic c;
    logic dc;
    logic z;
  } flags_t;
endpackage

// *** rtl/sub_alu.sv ***
// subtract unit: file minus working register, optional borrow
// purely combinational; caller registers the outputs
`timescale 1ns/1ps
module sub_alu (
  input  wire logic [7:0]      file_val,   // minuend
  input  wire logic [7:0]      work_val,   // subtrahend
  input  wire logic            use_borrow, // borrow form
  input  wire logic            carry_in,   // current carry
  output tblwr_pkg::flags_t    flags,      // resulting flags
  output logic [7:0]           result      // difference
);
  import tblwr_pkg::*;
  logic [8:0] full;
  logic [4:0] low;
  logic       bin;
  always_comb begin
    // carry clear means a borrow is pending
    bin  = use_borrow & ~carry_in;
    full = {1'b0, file_val} + {1'b0, ~work_val} + {8'h00, ~bin};
    low  = {1'b0, file_val[3:0]} + {1'b0, ~work_val[3:0]} + {4'h0, ~bin};
    result   = full[7:0];
    flags.c  = full[8];
    flags.dc = low[4];
    flags.z  = (full[7:0] == 8'h00);
    flags.ov = (file_val[7] != work_val[7]) & (full[7] != file_val[7]);
  end
endmodule

// *** bench/pm_model.sv ***
// program memory behind the table-write block, internal or external
// assumes a word is offered on pm_wr_stb and is_int follows the target
`timescale 1ns/1ps
module pm_model #(
  parameter int unsigned DONE_DLY = 6  // internal programming pulse
) (
  input  wire logic        ref_clk,   // core clock
  input  wire logic        rst_n,     // sync reset, active low
  input  wire logic        is_int,    // target is internal memory
  input  wire logic        pm_wr_stb, // word strobe
  input  wire logic        pm_prog_en,// programming voltage present
  input  wire logic [15:0] pm_addr,   // word address
  input  wire logic [15:0] pm_data,   // word data
  output logic             pm_done,   // programming pulse over
  output logic [15:0]      last_addr, // last address offered
  output logic [15:0]      last_data, // last word offered
  output logic [7:0]       n_prog     // words really programmed
);
  int unsigned cnt;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt       <= 0;
      pm_done   <= 1'b0;
      last_addr <= 16'h0000;
      last_data <= 16'h0000;
      n_prog    <= 8'h00;
    end else begin
      pm_done <= 1'b0;
      if (pm_wr_stb) begin
        last_addr <= pm_addr;
        last_data <= pm_data;
        // external memory takes the word at once and never answers
        cnt <= is_int ? DONE_DLY : 0;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
        pm_done <= (cnt == 1);
      end
      // without programming voltage the pulse runs but nothing sticks
      if (pm_done && pm_prog_en) begin
        n_prog <= n_prog + 8'h01;
      end
    end
  end
endmodule

// *** bench/tblwr_exec_bench.sv ***
// self-checking bench for the table-write and subtract block
// assumes the program memory model answers internal writes slowly
`timescale 1ns/1ps
module tblwr_exec_bench;
  import tblwr_pkg::*;
  logic        ref_clk, rst_n, cmd_valid, ptr_load, bank_wr, work_wr;
  logic        ptr_is_int, vpp_high, irq, pm_done, busy, pm_wr_stb;
  logic        pm_prog_en, file_wr;
  cmd_t        cmd;
  flags_t      flags;
  logic [15:0] ptr_val, pm_addr, pm_data, ptr_out, latch_out;
  logic [15:0] last_addr, last_data;
  logic [7:0]  bank_val, work_val, bank_rd, work_rd, file_val, n_prog;
  int          n_fail, samples_checked, cycles, n;

  tblwr_exec #(.SMALL_VARIANT(1'b1)) i_tblwr_exec (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .ptr_load(ptr_load), .ptr_val(ptr_val), .bank_wr(bank_wr),
    .bank_val(bank_val), .work_wr(work_wr), .work_val(work_val),
    .ptr_is_int(ptr_is_int), .vpp_high(vpp_high), .irq(irq),
    .pm_done(pm_done), .busy(busy), .pm_wr_stb(pm_wr_stb),
    .pm_prog_en(pm_prog_en), .pm_addr(pm_addr), .pm_data(pm_data),
    .program_word_pointer(ptr_out), .program_word_latch(latch_out),
    .bank_select_reg(bank_rd), .working_reg(work_rd), .alu_flags(flags),
    .file_wr(file_wr), .file_wr_val(file_val));

  pm_model i_pm_model (
    .ref_clk(ref_clk), .rst_n(rst_n), .is_int(ptr_is_int),
    .pm_wr_stb(pm_wr_stb), .pm_prog_en(pm_prog_en), .pm_addr(pm_addr),
    .pm_data(pm_data), .pm_done(pm_done), .last_addr(last_addr),
    .last_data(last_data), .n_prog(n_prog));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic issue(input op_t op, input logic h, input logic inc,
                       input logic d, input logic [7:0] v);
    cmd = '{op, h, inc, d, v};
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
  endtask

  // counts cycles of busy, cut off so a stuck store cannot hang
  task automatic run_store(input logic h, input logic inc,
                           input logic [7:0] v, input int irq_at);
    issue(OP_STORE, h, inc, 1'b0, v);
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      if (n == irq_at) irq = 1'b1;
      tick(1);
      n++;
    end
    irq = 1'b0;
  endtask

  task automatic t_external();
    ptr_val = 16'h1230;
    ptr_load = 1'b1;
    tick(1);
    ptr_load = 1'b0;
    run_store(1'b0, 1'b1, 8'h5a, -1);
    chk(16'(n), 16'(PHASES * EXT_CYCLES));
    chk(latch_out, 16'h005a);
    chk(last_data, 16'h005a);
    chk(last_addr, 16'h1230);
    chk(ptr_out, 16'h1231);
    run_store(1'b1, 1'b0, 8'hc3, -1);
    chk(16'(n), 16'(PHASES * EXT_CYCLES));
    chk(last_data, 16'hc35a);
    chk(ptr_out, 16'h1231);
  endtask

  task automatic t_internal();
    logic [7:0] p;
    ptr_is_int = 1'b1;
    vpp_high = 1'b1;
    p = n_prog;
    run_store(1'b0, 1'b1, 8'h77, -1);
    chk(16'(n > 6), 16'h0001);
    chk(16'(n_prog), 16'(p + 8'h01));
    chk(last_addr, 16'h1231);
    chk(ptr_out, 16'h1232);
    // normal supply: the pulse runs to done, yet nothing sticks
    vpp_high = 1'b0;
    p = n_prog;
    run_store(1'b1, 1'b0, 8'h99, -1);
    chk(16'(n > 6), 16'h0001);
    chk(last_data, 16'h9977);
    chk(16'(n_prog), 16'(p));
    vpp_high = 1'b1;
    run_store(1'b0, 1'b0, 8'h11, 1);
    chk(16'(n <= 3), 16'h0001);
    tick(10);
    chk(last_data, 16'h9911);
    chk(ptr_out, 16'h1232);
    ptr_is_int = 1'b0;
  endtask

  task automatic t_subtract();
    work_val = 8'h02;
    work_wr = 1'b1;
    tick(1);
    work_wr = 1'b0;
    issue(OP_SUB, 1'b0, 1'b0, 1'b1, 8'h03);
    chk(16'(file_wr), 16'h0001);
    tick(1);
    chk(16'(file_wr), 16'h0000);
    chk(16'(file_val), 16'h0001);
    chk(16'(flags), 16'h0006);
    issue(OP_SUB, 1'b0, 1'b0, 1'b1, 8'h01);
    tick(1);
    chk(16'(file_val), 16'h00ff);
    chk(16'(flags), 16'h0000);
    // carry is clear now, so the borrow form takes one more away
    issue(OP_SUBB, 1'b0, 1'b0, 1'b0, 8'h19);
    chk(16'(file_wr), 16'h0000);
    tick(1);
    chk(16'(work_rd), 16'h0016);
    chk(16'(flags), 16'h0006);
  endtask

  task automatic t_bank();
    bank_val = 8'ha5;
    bank_wr = 1'b1;
    tick(1);
    bank_wr = 1'b0;
    tick(1);
    chk(16'(bank_rd), 16'h0005);
  endtask

  initial begin
    {rst_n, cmd_valid, ptr_load, bank_wr, work_wr} = 5'h00;
    {ptr_is_int, vpp_high, irq} = 3'h0;
    cmd = '0;
    ptr_val = 16'h0000;
    bank_val = 8'h00;
    work_val = 8'h00;
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    tick(3);
    rst_n = 1'b1;
    chk(ptr_out, PTR_RST);
    chk(latch_out, LATCH_RST);
    t_external();
    t_internal();
    t_subtract();
    t_bank();
    tally_and_finish();
  end
endmodule
